// [latc_pkg.sv]
// Purpose: Shared constants and types for the lock acquisition and tracking control block.
// Assumes: One 200 MHz clock, 32-bit register port, word-indexed register addresses.
// Notes: Register indices are word addresses on the plain register port.
package latc_pkg;

    // ==========================================================
    // Register map.
    // ==========================================================
    localparam logic [7:0] LATC_ADDR_CTRL = 8'h17; // Acquisition/tracking control.
    localparam logic [7:0] LATC_ADDR_HALT = 8'h18; // Halt location, write only.
    localparam logic [7:0] LATC_ADDR_RESTART = 8'h19; // Restart location, write only.
    localparam logic [7:0] LATC_ADDR_STAT = 8'h1A; // Sticky event status.
    localparam logic [7:0] LATC_ADDR_MASK = 8'h1B; // Event mask.
    localparam logic [7:0] LATC_ADDR_STATE = 8'h1C; // Live state readback.

    // ==========================================================
    // Control field positions and reset values.
    // ==========================================================
    localparam int LATC_BIT_SWEEP_EN = 0;
    localparam int LATC_BIT_LOCK = 2;
    localparam int LATC_BIT_ACQ_SEL = 3;
    localparam int LATC_BIT_SM_CTRL = 4;
    localparam int LATC_LSB_SWEEP_LEN = 5;
    localparam int LATC_LSB_VERIFY_LEN = 9;
    localparam int LATC_BIT_CONT_SWEEP = 13;
    localparam int LATC_BIT_FL_EN = 14;
    localparam logic [15:0] LATC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] LATC_CTRL_WMASK = 16'h7FFD; // Bits 15 and 1 read zero.
    localparam logic [3:0] LATC_EVT_RESET = 4'h0;

    // Event bit positions in the status and mask registers.
    localparam int LATC_EVT_LOCK = 0;
    localparam int LATC_EVT_FALSE_LOCK = 1;
    localparam int LATC_EVT_LOSS = 2;
    localparam int LATC_EVT_STOPPED = 3;

    // ==========================================================
    // Types.
    // ==========================================================
    typedef enum logic [2:0] {
        LATC_ACQUIRE,
        LATC_VERIFY,
        LATC_LOCKED,
        LATC_FALSE_LOCK
    } latc_state_e;

    // Sixteen bits in register order; the reserved bits 15 and 1 keep their places.
    typedef struct packed {
        logic rsvd_hi;
        logic fl_en;
        logic cont_sweep;
        logic [3:0] verify_len;
        logic [3:0] sweep_len;
        logic sm_ctrl;
        logic acq_sel;
        logic lock;
        logic rsvd_lo;
        logic sweep_en;
    } latc_ctrl_s;

    typedef struct packed {
        logic acq_params;
        logic sweep_gate;
        logic integ_run;
        logic locked;
    } latc_out_s;

endpackage : latc_pkg

// [latc_ctrl.sv]
// Purpose: Acquisition/tracking control register and lock detector sequencer.
// Assumes: Integration-end, lock, overflow and compute strobes come from same-clock logic.
// Notes: Accumulator and sweep datapaths sit outside; this block steers them.
// Notes on behaviour
// RL1: Software writes zero to bits 15 and 1; upper sixteen bits unused.
// RL2: Bit 14 enables false-lock detection, only in the verify state.
// RL3: Enabled overflow before integration end forces the false-lock state.
// RL4: Disabled false-lock detection makes overflow irrelevant to sequencing.
// RL5: Bit 13 picks stepped sweep at 0, continuous sweep at 1.
// RL6: Bits 12-9 give verify periods, 0 to 15, before declaring lock.
// RL7: Continuous sweep: bits 8-5 count integration cycles of forced sweep.
// RL8: Stepped sweep: bits 8-5 count compute cycles with sweep input enabled.
// RL9: Bit 4 gives sequencing to microprocessor at 0, state machine at 1.
// RL10: Microprocessor control integrates the full period, ignoring rollover.
// RL11: Microprocessor control stops the accumulator after each period until restart.
// RL12: Under microprocessor control software chooses parameters and enables sweep.
// RL13: Bit 3 picks tracking parameters at 0, acquisition parameters at 1; under state-machine control the state picks them instead.
// RL14: Bit 2 drives the lock indication on status bit 6; under state-machine control the locked state drives it instead.
// RL15: Switching to state machine with bit 2 set starts in locked state.
// RL16: Bit 0 gates sweep into lag path, only under microprocessor control.
// RL17: False-lock detection suits square-wave data; otherwise disable it.
// RL18: Halt write stops sequencer at period end until a restart write; the stepped-sweep false-lock countdown and exit still run while halted.
// RL19: Verify state uses the false-lock accumulator with tracking parameters.
//
// The address-and-strobe port was decided locally.
module latc_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic integ_end,
    input wire logic lock_detect,
    input wire logic fl_overflow,
    input wire logic compute_tick,
    input wire logic [5:0] status_low,
    output logic [6:0] status_output_bus,
    output logic integ_run,
    output logic acq_params,
    output logic sweep_gate,
    output logic fl_acc_use,
    output logic irq
);

    // ==========================================================
    // Register write decode.
    // ==========================================================
    latc_pkg::latc_ctrl_s ctrl;
    logic [3:0] evt_stat;
    logic [3:0] evt_mask;
    logic [3:0] evt_set;
    logic halted;
    logic halt_req;
    logic prev_sm_ctrl;
    logic up_wait;
    logic [3:0] cnt;
    latc_pkg::latc_state_e state;
    latc_pkg::latc_state_e next_state;

    wire wr_ctrl = reg_wr && (reg_addr == latc_pkg::LATC_ADDR_CTRL);
    wire wr_halt = reg_wr && (reg_addr == latc_pkg::LATC_ADDR_HALT);
    wire wr_restart = reg_wr && (reg_addr == latc_pkg::LATC_ADDR_RESTART);
    wire wr_stat = reg_wr && (reg_addr == latc_pkg::LATC_ADDR_STAT);
    wire wr_mask = reg_wr && (reg_addr == latc_pkg::LATC_ADDR_MASK);
    wire [15:0] ctrl_bits = ctrl;
    wire sm_mode = ctrl.sm_ctrl; // see RL9

    // Handover from microprocessor to state machine.
    wire sm_enter = sm_mode && !prev_sm_ctrl;

    // Overflow only counts when enabled and in verify.
    wire fl_hit = ctrl.fl_en && fl_overflow && (state == latc_pkg::LATC_VERIFY) && !integ_end; // see RL2, RL3, RL4

    // Sequencer step: an integration end while running under state-machine control.
    wire sm_step = sm_mode && !halted && integ_end;
    wire cnt_done = (cnt == 4'h0);

    // ==========================================================
    // Sequencer next state.
    // ==========================================================
    always_comb
    begin
        next_state = state;
        unique case (state)
            latc_pkg::LATC_ACQUIRE:
            begin
                if (sm_step && lock_detect)
                begin
                    next_state = (ctrl.verify_len == 4'h0) ? latc_pkg::LATC_LOCKED
                                                           : latc_pkg::LATC_VERIFY; // see RL6
                end
            end
            latc_pkg::LATC_VERIFY:
            begin
                if (fl_hit && !halted)
                begin
                    next_state = latc_pkg::LATC_FALSE_LOCK; // see RL3
                end
                else if (sm_step && !lock_detect)
                begin
                    next_state = latc_pkg::LATC_ACQUIRE;
                end
                else if (sm_step && cnt == 4'h1)
                begin
                    next_state = latc_pkg::LATC_LOCKED; // see RL6
                end
            end
            latc_pkg::LATC_LOCKED:
            begin
                if (sm_step && !lock_detect)
                begin
                    next_state = latc_pkg::LATC_ACQUIRE;
                end
            end
            latc_pkg::LATC_FALSE_LOCK:
            begin
                if (ctrl.cont_sweep ? (sm_step && cnt_done) : (compute_tick && cnt_done))
                begin
                    next_state = latc_pkg::LATC_ACQUIRE; // see RL7, RL8
                end
            end
        endcase
    end

    // ==========================================================
    // Sequencer state, counters and handover.
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= latc_pkg::LATC_ACQUIRE;
            cnt <= 4'h0;
            prev_sm_ctrl <= 1'b0;
        end
        else
        begin
            prev_sm_ctrl <= sm_mode;
            if (sm_enter)
            begin
                state <= ctrl.lock ? latc_pkg::LATC_LOCKED : latc_pkg::LATC_ACQUIRE; // see RL15
                cnt <= 4'h0;
            end
            else if (!sm_mode)
            begin
                state <= latc_pkg::LATC_ACQUIRE;
            end
            else
            begin
                state <= next_state;
                if (next_state != state)
                begin
                    cnt <= (next_state == latc_pkg::LATC_VERIFY) ? ctrl.verify_len
                                                                 : ctrl.sweep_len;
                end
                else if (!cnt_done && (ctrl.cont_sweep || state != latc_pkg::LATC_FALSE_LOCK)
                         && sm_step)
                begin
                    cnt <= cnt - 4'h1;
                end
                else if (!cnt_done && !ctrl.cont_sweep && compute_tick
                         && state == latc_pkg::LATC_FALSE_LOCK)
                begin
                    cnt <= cnt - 4'h1; // see RL8
                end
            end
        end
    end

    // ==========================================================
    // Halt, restart and microprocessor period stop.
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            halt_req <= 1'b0;
            halted <= 1'b0;
            up_wait <= 1'b0;
        end
        else
        begin
            if (wr_restart)
            begin
                halt_req <= 1'b0;
                halted <= 1'b0; // see RL18
            end
            else if (wr_halt)
            begin
                halt_req <= 1'b1;
            end
            else if (halt_req && integ_end)
            begin
                halted <= 1'b1; // see RL18
                halt_req <= 1'b0;
            end
            if (!sm_mode && integ_end && !wr_restart)
            begin
                up_wait <= 1'b1; // see RL11
            end
            else if (wr_restart || sm_mode)
            begin
                up_wait <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Control, status and mask registers.
    // ==========================================================
    assign evt_set[latc_pkg::LATC_EVT_LOCK] = sm_mode && state != latc_pkg::LATC_LOCKED
                                              && next_state == latc_pkg::LATC_LOCKED;
    assign evt_set[latc_pkg::LATC_EVT_FALSE_LOCK] = sm_mode && fl_hit && !halted;
    assign evt_set[latc_pkg::LATC_EVT_LOSS] = sm_mode && state == latc_pkg::LATC_LOCKED
                                              && next_state == latc_pkg::LATC_ACQUIRE;
    assign evt_set[latc_pkg::LATC_EVT_STOPPED] = (halt_req && integ_end && !wr_restart)
                                                 || (!sm_mode && integ_end);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= latc_pkg::LATC_CTRL_RESET;
            evt_stat <= latc_pkg::LATC_EVT_RESET;
            evt_mask <= latc_pkg::LATC_EVT_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl <= reg_wdata[15:0] & latc_pkg::LATC_CTRL_WMASK; // see RL1
            end
            if (wr_mask)
            begin
                evt_mask <= reg_wdata[3:0];
            end
            // Set wins over a write-one clear in the same cycle.
            evt_stat <= (evt_stat & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | evt_set;
        end
    end

    // ==========================================================
    // Read data, one cycle after the strobe.
    // ==========================================================
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (reg_addr)
            latc_pkg::LATC_ADDR_CTRL: next_rdata = {16'h0000, ctrl_bits};
            latc_pkg::LATC_ADDR_STAT: next_rdata = {28'h0000000, evt_stat};
            latc_pkg::LATC_ADDR_MASK: next_rdata = {28'h0000000, evt_mask};
            latc_pkg::LATC_ADDR_STATE: next_rdata = {24'h000000, cnt, halted, up_wait,
                                                    2'(state)};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Outputs to the loop datapath.
    // ==========================================================
    wire lock_ind = sm_mode ? (state == latc_pkg::LATC_LOCKED) : ctrl.lock; // see RL14
    wire sm_sweep = (state == latc_pkg::LATC_FALSE_LOCK)
                    || (state == latc_pkg::LATC_ACQUIRE);
    wire sm_acq = (state == latc_pkg::LATC_ACQUIRE) || (state == latc_pkg::LATC_FALSE_LOCK);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_output_bus <= 7'h00;
            integ_run <= 1'b0;
            acq_params <= 1'b0;
            sweep_gate <= 1'b0;
            fl_acc_use <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            status_output_bus <= {lock_ind, status_low}; // see RL14
            integ_run <= sm_mode ? !halted : !up_wait; // see RL10, RL11
            acq_params <= sm_mode ? sm_acq : ctrl.acq_sel; // see RL13, RL19
            sweep_gate <= sm_mode ? sm_sweep : ctrl.sweep_en; // see RL16, RL5
            fl_acc_use <= sm_mode && (state == latc_pkg::LATC_VERIFY); // see RL19
            irq <= |(evt_stat & evt_mask);
        end
    end

endmodule : latc_ctrl

// [latc_ctrl_checker.sv]
// Purpose: Concurrent checks on the ports of the control block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: A shadow of the control word follows register writes.
module latc_ctrl_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic integ_end,
    input wire logic lock_detect,
    input wire logic fl_overflow,
    input wire logic compute_tick,
    input wire logic [5:0] status_low,
    input wire logic [6:0] status_output_bus,
    input wire logic integ_run,
    input wire logic acq_params,
    input wire logic sweep_gate,
    input wire logic fl_acc_use,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Shadow of the control word.
    // ==========================================================
    logic [15:0] sh;
    wire ctrl_wr = reg_wr && (reg_addr == latc_pkg::LATC_ADDR_CTRL);
    wire go_wr = reg_wr && (reg_addr == latc_pkg::LATC_ADDR_RESTART);
    wire up_mode = !sh[latc_pkg::LATC_BIT_SM_CTRL];
    // The shadow keeps only the writable bits, as the register does.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sh <= 16'h0000;
        else if (ctrl_wr)
            sh <= reg_wdata[15:0] & latc_pkg::LATC_CTRL_WMASK;
    end
    // ==========================================================
    // Assertions.
    // ==========================================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_RDATA_IDLE: assert property ($past(rst_n) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero when idle");
    AST_CTRL_READ: assert property ($past(rst_n) && $past(reg_rd) &&
        $past(reg_addr) == latc_pkg::LATC_ADDR_CTRL |-> reg_rdata == {16'h0000, $past(sh)})
        else $error("control read back wrong");
    AST_UNMAPPED: assert property ($past(reg_rd) && ($past(reg_addr) < 8'h17 ||
        $past(reg_addr) > 8'h1C) |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
    AST_ACQ_SEL: assert property ($past(rst_n) && $past(up_mode)
        |-> acq_params == $past(sh[3])) else $error("parameter set wrong");
    AST_LOCK_IND: assert property ($past(rst_n) && $past(up_mode)
        |-> status_output_bus[6] == $past(sh[2])) else $error("lock indication wrong");
    AST_STATUS_PASS: assert property ($past(rst_n) |->
        status_output_bus[5:0] == $past(status_low)) else $error("status bits wrong");
    AST_SWEEP_OFF: assert property ($past(rst_n) && $past(up_mode) &&
        !$past(sh[0]) |-> !sweep_gate) else $error("sweep gated while disabled");
    AST_UP_STOP: assert property (up_mode && integ_end && !go_wr ##1 up_mode &&
        !go_wr |-> ##1 !integ_run) else $error("integration not stopped");
    AST_VERIFY_TRACK: assert property (fl_acc_use |-> !acq_params)
        else $error("verify uses acquisition set");
endmodule : latc_ctrl_checker

bind latc_ctrl latc_ctrl_checker chk_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .integ_end, .lock_detect, .fl_overflow, .compute_tick, .status_low,
    .status_output_bus, .integ_run, .acq_params, .sweep_gate, .fl_acc_use, .irq);

// [latc_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the control block.
// Assumes: 200 MHz clock, reset held for 20 cycles.
// Notes: Random control words come from a fixed seed.
module latc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, integ_end = 1'b0, lock_detect = 1'b0;
    logic fl_overflow = 1'b0, compute_tick = 1'b0;
    logic [5:0] status_low = 6'h00;
    logic [31:0] reg_rdata, rv, d;
    logic [6:0] status_output_bus;
    logic integ_run, acq_params, sweep_gate, fl_acc_use, irq;
    int fail_count = 0;
    int checked = 0;
    int seed = 13986;
    latc_ctrl dut_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .integ_end, .lock_detect, .fl_overflow, .compute_tick, .status_low,
        .status_output_bus, .integ_run, .acq_params, .sweep_gate, .fl_acc_use, .irq);
    // ==========================================================
    // Clock and bench tasks.
    // ==========================================================
    always #2.5 sys_clk = ~sys_clk;
    // The compute strobe toggles freely so the sweep counter sees ticks.
    always @(posedge sys_clk) compute_tick <= ~compute_tick;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Expected control readback: only the writable low bits survive.
    function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
        return {16'h0000, w[15:0] & latc_pkg::LATC_CTRL_WMASK};
    endfunction : exp_ctrl
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic pulse(input int k);
        @(posedge sys_clk) {integ_end, fl_overflow} <= (k == 0) ? 2'b10 : 2'b01;
        @(posedge sys_clk) {integ_end, fl_overflow} <= 2'b00;
    endtask : pulse
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // ==========================================================
    // Watchdog and main sequence.
    // ==========================================================
    initial
    begin
        #20000;
        fail_count++;
        end_sim();
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(latc_pkg::LATC_ADDR_CTRL, d);
        check(d, {16'h0000, latc_pkg::LATC_CTRL_RESET});
        rd(latc_pkg::LATC_ADDR_MASK, d);
        check(d, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            rv = (i == 0) ? 32'hFFFF_FFEF : $random(seed);
            rv[latc_pkg::LATC_BIT_SM_CTRL] = 1'b0;
            @(posedge sys_clk) status_low <= rv[21:16];
            wr(latc_pkg::LATC_ADDR_CTRL, rv);
            rd(latc_pkg::LATC_ADDR_CTRL, d);
            check(d, exp_ctrl(rv));
            check(acq_params, rv[3]);
            check(status_output_bus, {rv[2], rv[21:16]});
            if (!rv[0]) check(sweep_gate, 1'b0);
        end
        rd(8'h05, d);
        check(d, 32'h0);
        rd(8'hFF, d);
        check(d, 32'h0);
        // Microprocessor control: integration halts after each period.
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h0);
        wr(latc_pkg::LATC_ADDR_RESTART, 32'h0);
        tick(2);
        check(integ_run, 1'b1);
        pulse(0);
        tick(2);
        check(integ_run, 1'b0);
        // Handing over with the lock bit set starts locked.
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h0004);
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h0014);
        rd(latc_pkg::LATC_ADDR_STATE, d);
        check(d[1:0], 2'h2);
        // Zero verify length locks on the first good period.
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h0);
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h0010);
        wr(latc_pkg::LATC_ADDR_STAT, 32'hF);
        rd(latc_pkg::LATC_ADDR_STATE, d);
        check(d[1:0], 2'h0);
        @(posedge sys_clk) lock_detect <= 1'b1;
        pulse(0);
        rd(latc_pkg::LATC_ADDR_STATE, d);
        check(d[1:0], 2'h2);
        rd(latc_pkg::LATC_ADDR_STAT, d);
        check(d, 32'h1);
        wr(latc_pkg::LATC_ADDR_MASK, 32'h1);
        tick(2);
        check(irq, 1'b1);
        wr(latc_pkg::LATC_ADDR_MASK, 32'h0);
        tick(2);
        check(irq, 1'b0);
        wr(latc_pkg::LATC_ADDR_STAT, 32'h1);
        rd(latc_pkg::LATC_ADDR_STAT, d);
        check(d, 32'h0);
        // Halt stops the sequencer at period end until restarted.
        wr(latc_pkg::LATC_ADDR_HALT, 32'h0);
        pulse(0);
        tick(2);
        check(integ_run, 1'b0);
        wr(latc_pkg::LATC_ADDR_RESTART, 32'h0);
        tick(2);
        check(integ_run, 1'b1);
        // Verify length one, then overflow with detection off and on.
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h0);
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h0210);
        pulse(0);
        rd(latc_pkg::LATC_ADDR_STATE, d);
        check(d[1:0], 2'h1);
        check(fl_acc_use, 1'b1);
        pulse(1);
        rd(latc_pkg::LATC_ADDR_STATE, d);
        check(d[1:0], 2'h1);
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h43F0);
        pulse(1);
        rd(latc_pkg::LATC_ADDR_STATE, d);
        check(d[1:0], 2'h3);
        check(sweep_gate, 1'b1);
        // Stepped sweep leaves the false-lock state after sixteen compute ticks.
        tick(40);
        rd(latc_pkg::LATC_ADDR_STATE, d);
        check(d[1:0], 2'h0);
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h0);
        wr(latc_pkg::LATC_ADDR_CTRL, 32'h0210);
        pulse(0);
        pulse(0);
        rd(latc_pkg::LATC_ADDR_STATE, d);
        check(d[1:0], 2'h2);
        end_sim();
    end
endmodule : latc_ctrl_tb_top
